/* File: inc/lvdc_defines.svh */
// constants for the low-voltage detect control block
// assumes inclusion by bare name from design files
`ifndef LVDC_DEFINES_SVH
`define LVDC_DEFINES_SVH
`define LVDC_BIT_LEVEL 0
`define LVDC_BIT_MODE 1
`define LVDC_BIT_SRC 2
`define LVDC_BIT_EN 7
`define LVDC_CTRL_RST 8'h00
`define LVDC_SEL_RST 4'h0
`define LVDC_STAB_NS 10000
`define LVDC_CLK_NS 100
`define LVDC_STAB_CYC ((`LVDC_STAB_NS) / (`LVDC_CLK_NS))
`endif

/* File: inc/lvdc_pkg.sv */
// types shared by the low-voltage detect control block
// assumes nothing beyond a SystemVerilog compiler
package lvdc_pkg;
   typedef logic [7:0] lvdc_byte_t;
   typedef logic [3:0] lvdc_sel_t;
endpackage

/* File: design/lvdc_core.sv */
// low-voltage detect control: control register, level flag, irq/reset request
// assumes analog comparators outside; software writes over plain ports
//
// Operation
// - source bit one selects external pin comparator
// - detector runs only while enable is set
// - level flag shows synchronized comparison result
// - mode zero raises interrupt request on detection
// - any reset sets the interrupt mask
// - in mode zero, detection sets pending flag, raises request
// - disabling below threshold raises request too
// - pending flag cleared by software pulsing pend_clr_i high
// - mode one raises internal reset on detection
// - no reset if level already below when mode set while enabled
// - source zero uses four-bit supply threshold select
`include "lvdc_defines.svh"
module lvdc_core (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // control register write, read
   input wire logic ctrl_we_i,
   input wire lvdc_pkg::lvdc_byte_t ctrl_wdata_i,
   output lvdc_pkg::lvdc_byte_t ctrl_rdata_o,
   // level select register
   input wire logic sel_we_i,
   input wire lvdc_pkg::lvdc_sel_t sel_wdata_i,
   output lvdc_pkg::lvdc_sel_t supply_level_sel_o,
   // interrupt flags
   input wire logic mask_we_i,
   input wire logic mask_wdata_i,
   output logic detect_irq_mask_o,
   input wire logic pend_clr_i,
   output logic detect_irq_pending_o,
   // comparators, async, high means level below threshold
   input wire logic supply_below_i,
   input wire logic external_level_pin_below_i,
   // analog controls and requests
   output logic comp_enable_o,
   output logic comp_external_sel_o,
   output logic detect_irq_request_o,
   output logic detect_reset_req_o
);
   import lvdc_pkg::*;

   logic detect_enable_r, detect_reset_mode_r, detect_source_select_r;
   lvdc_sel_t sel_r;
   logic sup_s1_r, sup_s2_r, ext_s1_r, ext_s2_r;
   logic below_d_r;
   logic mask_r, pend_r, irq_r, rst_r;

   // only the second stage is read; the first may be metastable
   always_ff @(posedge clk_i) begin
      sup_s1_r <= supply_below_i;
      sup_s2_r <= sup_s1_r;
      ext_s1_r <= external_level_pin_below_i;
      ext_s2_r <= ext_s1_r;
   end

   wire below_w = detect_source_select_r ? ext_s2_r : sup_s2_r;
   wire level_w = detect_enable_r & below_w;
   wire edge_w = detect_enable_r & (below_w != below_d_r);
   wire off_w = ctrl_we_i & detect_enable_r & ~ctrl_wdata_i[`LVDC_BIT_EN] & below_w;
   wire irq_ev_w = (edge_w & ~detect_reset_mode_r) | off_w;
   // reset only on a fall below; already below when mode set gives none
   wire rst_ev_w = detect_enable_r & detect_reset_mode_r & below_w & ~below_d_r;

   // control register; one write moves all three fields together
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         detect_enable_r <= 1'b0;
         detect_reset_mode_r <= 1'b0;
         detect_source_select_r <= 1'b0;
      end else if (ctrl_we_i) begin
         detect_enable_r <= ctrl_wdata_i[`LVDC_BIT_EN];
         detect_reset_mode_r <= ctrl_wdata_i[`LVDC_BIT_MODE];
         detect_source_select_r <= ctrl_wdata_i[`LVDC_BIT_SRC];
      end
   end

   // supply threshold select, only meaningful with source zero
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sel_r <= `LVDC_SEL_RST;
      end else if (sel_we_i) begin
         sel_r <= sel_wdata_i;
      end
   end

   // mask comes up set so no request escapes before software is ready
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         mask_r <= 1'b1;
      end else if (mask_we_i) begin
         mask_r <= mask_wdata_i;
      end
   end

   // new detection wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         pend_r <= 1'b0;
      end else begin
         pend_r <= irq_ev_w | (pend_r & ~pend_clr_i);
      end
   end

   // history cleared while off, so enabling below gives one event
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         below_d_r <= 1'b0;
      end else begin
         below_d_r <= detect_enable_r ? below_w : 1'b0;
      end
   end

   // requests are single-cycle pulses
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         irq_r <= 1'b0;
         rst_r <= 1'b0;
      end else begin
         irq_r <= irq_ev_w & ~mask_r;
         rst_r <= rst_ev_w;
      end
   end

   assign ctrl_rdata_o = {detect_enable_r, 4'h0, detect_source_select_r, detect_reset_mode_r, level_w};
   assign supply_level_sel_o = sel_r;
   assign detect_irq_mask_o = mask_r;
   assign detect_irq_pending_o = pend_r;
   assign comp_enable_o = detect_enable_r;
   assign comp_external_sel_o = detect_source_select_r;
   assign detect_irq_request_o = irq_r;
   assign detect_reset_req_o = rst_r;

   chk_reset_sets_mask: assert property (@(posedge clk_i) !nrst_i |=> detect_irq_mask_o)
      else $error("mask not set by reset");
   chk_reset_clears_ctrl: assert property (@(posedge clk_i) !nrst_i |=> !comp_enable_o && !detect_reset_req_o)
      else $error("control not cleared by reset");
   chk_pend_on_event: assert property (@(posedge clk_i) disable iff (!nrst_i) irq_ev_w |=> detect_irq_pending_o)
      else $error("pending not set on detection");
   chk_pend_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      pend_clr_i && !irq_ev_w |=> !detect_irq_pending_o)
      else $error("pending not cleared");
   chk_off_below_irq: assert property (@(posedge clk_i) disable iff (!nrst_i) off_w |=> detect_irq_pending_o)
      else $error("disable below threshold lost");
   chk_no_reset_irqmode: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !detect_reset_mode_r |=> !detect_reset_req_o)
      else $error("reset in interrupt mode");
   chk_reset_mode_req: assert property (@(posedge clk_i) disable iff (!nrst_i)
      detect_reset_mode_r && detect_enable_r && $rose(below_w) |=> detect_reset_req_o)
      else $error("reset mode detection missed");
   chk_no_reset_above: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !below_w |=> !detect_reset_req_o)
      else $error("reset while above threshold");
   chk_disabled_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !detect_enable_r |-> ctrl_rdata_o[`LVDC_BIT_LEVEL] == 1'b0)
      else $error("level shown while disabled");
   chk_source_select: assert property (@(posedge clk_i) disable iff (!nrst_i)
      detect_enable_r && detect_source_select_r |-> ctrl_rdata_o[`LVDC_BIT_LEVEL] == ext_s2_r)
      else $error("wrong source");
   // synchroniser checked end to end; the first stage is never read
   chk_sync_delay: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sup_s2_r == $past(supply_below_i, 2))
      else $error("supply sync stage broken");
   chk_sync_ext: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ext_s2_r == $past(external_level_pin_below_i, 2))
      else $error("pin sync stage broken");

   // register writes and level flag source
   chk_enable_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctrl_we_i |=> comp_enable_o == $past(ctrl_wdata_i[`LVDC_BIT_EN]))
      else $error("enable write lost");
   chk_source_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      ctrl_we_i |=> comp_external_sel_o == $past(ctrl_wdata_i[`LVDC_BIT_SRC]))
      else $error("source write lost");
   chk_sel_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sel_we_i |=> supply_level_sel_o == $past(sel_wdata_i))
      else $error("level select write lost");
   chk_supply_source: assert property (@(posedge clk_i) disable iff (!nrst_i)
      detect_enable_r && !detect_source_select_r |-> ctrl_rdata_o[`LVDC_BIT_LEVEL] == sup_s2_r)
      else $error("supply not monitored");
   chk_level_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
      detect_enable_r |-> ctrl_rdata_o[`LVDC_BIT_LEVEL] == below_w)
      else $error("level flag wrong");
   chk_mask_only_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !mask_we_i |=> $stable(detect_irq_mask_o))
      else $error("mask moved without write");

   // flags and requests
   chk_pend_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !irq_ev_w && !pend_clr_i |=> $stable(detect_irq_pending_o))
      else $error("pending moved on its own");
   chk_reset_clears_flags: assert property (@(posedge clk_i)
      !nrst_i |=> !detect_irq_pending_o && !detect_irq_request_o)
      else $error("flags not cleared by reset");
   chk_irq_unmasked: assert property (@(posedge clk_i) disable iff (!nrst_i)
      irq_ev_w && !mask_r |=> detect_irq_request_o)
      else $error("unmasked request missed");
   chk_irq_masked_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
      detect_irq_mask_o |=> !detect_irq_request_o)
      else $error("request while masked");
   chk_irq_needs_event: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !irq_ev_w |=> !detect_irq_request_o)
      else $error("request without detection");
   chk_off_below_req: assert property (@(posedge clk_i) disable iff (!nrst_i)
      off_w && !mask_r |=> detect_irq_request_o)
      else $error("disable below threshold gave no request");
   chk_reset_pulse: assert property (@(posedge clk_i) disable iff (!nrst_i)
      detect_reset_req_o |=> !detect_reset_req_o)
      else $error("reset request longer than one cycle");
   chk_disabled_no_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !detect_enable_r |=> !detect_reset_req_o)
      else $error("reset request while disabled");

   cov_irq_masked: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_ev_w && mask_r);
   cov_irq_out: cover property (@(posedge clk_i) disable iff (!nrst_i) detect_irq_request_o);
   cov_reset_out: cover property (@(posedge clk_i) disable iff (!nrst_i) detect_reset_req_o);
   cov_off_below: cover property (@(posedge clk_i) disable iff (!nrst_i) off_w);
   // set and clear together is the race the pending flag must survive
   cov_set_clear_race: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_ev_w && pend_clr_i);
endmodule

/* File: dv/lvdc_core_tb_top.sv */
// bench for lvdc_core: plain register ports driven at the falling edge
// assumes lvdc_pkg compiled first and lvdc_defines.svh on the include path
`include "lvdc_defines.svh"
module lvdc_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import lvdc_pkg::*;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
   logic clk_i = 0, nrst_i = 0, ctrl_we_i = 0, sel_we_i = 0, mask_we_i = 0, mask_wdata_i = 0;
   logic pend_clr_i = 0, sup_b = 0, ext_b = 0, mask, pend, cen, cext, irq, rreq;
   lvdc_byte_t ctrl_wdata_i = 8'h00, rdata;
   lvdc_sel_t sel_wdata_i = 4'h0, sel;
   int error_cnt = 0, n_compared = 0, irq_cnt = 0, rreq_cnt = 0;
   lvdc_core dut (.clk_i(clk_i), .nrst_i(nrst_i), .ctrl_we_i(ctrl_we_i), .ctrl_wdata_i(ctrl_wdata_i),
      .ctrl_rdata_o(rdata), .sel_we_i(sel_we_i), .sel_wdata_i(sel_wdata_i), .supply_level_sel_o(sel),
      .mask_we_i(mask_we_i), .mask_wdata_i(mask_wdata_i), .detect_irq_mask_o(mask), .pend_clr_i(pend_clr_i),
      .detect_irq_pending_o(pend), .supply_below_i(sup_b), .external_level_pin_below_i(ext_b),
      .comp_enable_o(cen), .comp_external_sel_o(cext), .detect_irq_request_o(irq), .detect_reset_req_o(rreq));
   initial forever #50 clk_i = ~clk_i;
   // requests are one-cycle pulses; sampled mid-cycle to avoid an edge race
   always @(negedge clk_i) begin
      irq_cnt += irq;
      rreq_cnt += rreq;
   end
   task tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task wc(input lvdc_byte_t d);
      ctrl_wdata_i = d;
      ctrl_we_i = 1;
      tick(1);
      ctrl_we_i = 0;
   endtask
   task clr;
      pend_clr_i = 1;
      tick(1);
      pend_clr_i = 0;
   endtask
   task stop_test;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // whole run is about 16 us, so 50 us is ample
   initial begin
      #50us;
      error_cnt++;
      stop_test;
   end
   initial begin
      tick(6);
      nrst_i = 1;
      tick(1);
      `CHK(rdata, 8'h00)
      `CHK(mask, 1'b1)
      `CHK(pend, 1'b0)
      wc(8'h84);
      tick(`LVDC_STAB_CYC);
      `CHK({cen, cext}, 2'b11)
      `CHK(rdata, 8'h84)
      ext_b = 1;
      tick(6);
      `CHK(rdata, 8'h85)
      `CHK(pend, 1'b1)
      `CHK(irq_cnt, 0)
      clr;
      mask_we_i = 1;
      tick(1);
      mask_we_i = 0;
      `CHK(pend, 1'b0)
      ext_b = 0;
      tick(6);
      `CHK(irq_cnt, 1)
      `CHK(pend, 1'b1)
      `CHK(rdata, 8'h84)
      clr;
      wc(8'h00);
      irq_cnt = 0;
      sel_wdata_i = 4'hA;
      sel_we_i = 1;
      tick(1);
      sel_we_i = 0;
      `CHK(sel, 4'hA)
      wc(8'h80);
      tick(1);
      `CHK(cext, 1'b0)
      sup_b = 1;
      tick(6);
      `CHK(irq_cnt, 1)
      `CHK(rdata, 8'h81)
      clr;
      wc(8'h00);
      tick(3);
      `CHK(irq_cnt, 2)
      `CHK(pend, 1'b1)
      // no enable here, so the fall must be ignored
      sup_b = 0;
      tick(4);
      wc(8'h82);
      tick(4);
      `CHK(rreq_cnt, 0)
      sup_b = 1;
      tick(6);
      `CHK(rreq_cnt, 1)
      `CHK(irq_cnt, 2)
      nrst_i = 0;
      tick(3);
      nrst_i = 1;
      tick(1);
      `CHK({mask, rdata, sel}, 13'h1000)
      stop_test;
   end
endmodule
